// File: bench/cfr_can_node.sv
`timescale 1ns/1ns
module cfr_can_node #(
  parameter int          BIT_CYC = 8,
  parameter logic [15:0] BODY    = 16'h0D6A
) (
  input  logic ref_clk,
  output logic can_rx
);
  initial can_rx = 1'b1;
  // body ends in the acknowledge slot, dominant
  task automatic send();
    for (int i = 15; i >= 0; i--) begin
      can_rx <= BODY[i]; // at most two recessive in a row
      repeat (BIT_CYC) @(posedge ref_clk); // eight quanta
    end
    can_rx <= 1'b1; // delimiter and end of frame
    repeat (10 * BIT_CYC) @(posedge ref_clk);
  endtask
endmodule

// File: bench/cfr_rx_fifo_checker.sv
`timescale 1ns/1ns
module cfr_rx_fifo_checker (
  input logic        ref_clk,
  input logic        rst,
  input logic        can_rx,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       rd;
  logic [4:0] low_run;
  logic [6:0] high_run;
  assign rd = hsel & hready & htrans[1] & !hwrite;
  // saturating runs of the pin, so long idle never wraps
  always_ff @(posedge ref_clk) begin
    if (rst || can_rx) low_run <= 5'h00;
    else if (low_run != 5'h1F) low_run <= low_run + 5'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !can_rx) high_run <= 7'h00;
    else if (high_run != 7'h7F) high_run <= high_run + 7'h01;
  end
  sequence rd_at(logic [7:0] a);
    rd && haddr[7:0] == a;
  endsequence
  // pin held long enough to pass the synchroniser
  sequence rx_held;
    $stable(can_rx) [*7];
  endsequence
  a_count_field: assert property (rd_at(cfr_pkg::RFR_OFS) |=>
    hrdata[31:2] == 30'h0) else $error("count read has upper bits");
  a_status_field: assert property (rd_at(cfr_pkg::MSR_OFS) |=>
    (hrdata & ~32'h20) == 32'h0) else $error("status stray bits");
  a_pin_recessive: assert property (rx_held ##0 can_rx ##0
    rd_at(cfr_pkg::DGR_OFS) |=> hrdata == 32'h8)
    else $error("pin read not recessive");
  a_pin_dominant: assert property (rx_held ##0 !can_rx ##0
    rd_at(cfr_pkg::DGR_OFS) |=> hrdata == 32'h0)
    else $error("pin read not dominant");
  a_read_stands: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  a_bt_floor: assert property (rd_at(cfr_pkg::BTR_OFS) |=>
    {1'b0, hrdata[6:3]} + {2'b0, hrdata[2:0]} >= 5'h05)
    else $error("segments below floor");
  a_active_dominant: assert property (low_run >= 5'h10 ##0
    rd_at(cfr_pkg::MSR_OFS) |=> hrdata[5]) else $error("not active");
  a_idle_clears: assert property (high_run >= 7'h50 ##0
    rd_at(cfr_pkg::MSR_OFS) |=> !hrdata[5]) else $error("still active");
endmodule
bind cfr_rx_fifo cfr_rx_fifo_checker cfr_rx_fifo_checker_i (
  .ref_clk(ref_clk), .rst(rst), .can_rx(can_rx), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// File: bench/cfr_rx_fifo_test.sv
`timescale 1ns/1ns
module cfr_rx_fifo_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        can_rx;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #25 ref_clk = ~ref_clk;
  cfr_can_node cfr_can_node_i (.ref_clk(ref_clk), .can_rx(can_rx));
  cfr_rx_fifo cfr_rx_fifo_i (
    .ref_clk(ref_clk), .rst(rst), .can_rx(can_rx), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string what);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, e, what);
    check({31'h0, hresp}, 32'h0, "response");
  endtask
  task automatic t_fill();
    wr(cfr_pkg::IMSK_OFS, 32'h4);
    for (int i = 1; i <= 4; i++) begin
      cfr_can_node_i.send();
      rchk(cfr_pkg::RFR_OFS, i > 3 ? 32'h3 : 32'(i), "count");
      check({31'h0, irq}, i > 3 ? 32'h1 : 32'h0, "irq");
    end
    rchk(cfr_pkg::IST_OFS, 32'h7, "events");
    wr(cfr_pkg::IST_OFS, 32'h7);
    rchk(cfr_pkg::IST_OFS, 32'h0, "events");
    check({31'h0, irq}, 32'h0, "irq");
    wr(cfr_pkg::RFR_OFS, 32'h20);
    rchk(cfr_pkg::RFR_OFS, 32'h2, "count");
  endtask
  // release swept across the load slot; one offset must coincide
  task automatic t_sweep(input logic defect);
    logic [31:0] r;
    wr(cfr_pkg::IST_OFS, 32'hF);
    wr(cfr_pkg::CTRL_OFS, {31'h0, defect});
    for (int d = 168; d < 198; d++) begin
      fork
        cfr_can_node_i.send();
        begin
          repeat (d) @(posedge ref_clk);
          wr(cfr_pkg::RFR_OFS, 32'h20);
        end
      join
      rchk(cfr_pkg::RFR_OFS, 32'h2, "count");
    end
    xfer(1'b0, cfr_pkg::IST_OFS, 32'h0, r);
    check(r & 32'hD, {28'h0, defect, 3'h1}, "events");
  endtask
  // host release sequence that keeps clear of the load slot when two messages are pending
  task automatic safe_release();
    logic [31:0] r;
    logic        busy;
    xfer(1'b0, cfr_pkg::RFR_OFS, 32'h0, r);
    busy = (r[1:0] == cfr_pkg::PEND_TWO);
    for (int n = 0; busy && n < 100; n++) begin
      xfer(1'b0, cfr_pkg::MSR_OFS, 32'h0, r);
      busy = r[cfr_pkg::MSR_ACTIVE_BIT];
      if (busy) begin
        xfer(1'b0, cfr_pkg::DGR_OFS, 32'h0, r);
        busy = r[cfr_pkg::DGR_RX_BIT];
      end
    end
    if (busy) begin
      error_cnt++;
      final_report();
    end
    // no other traffic between the last test and the release
    wr(cfr_pkg::RFR_OFS, 32'h20);
  endtask
  // defect mode with the safe sequence: no corruption at offsets 100 to 195 in steps of 5
  task automatic t_safe();
    logic [31:0] r;
    wr(cfr_pkg::IST_OFS, 32'hF);
    wr(cfr_pkg::CTRL_OFS, 32'h1);
    for (int d = 100; d < 200; d += 5) begin
      fork
        cfr_can_node_i.send();
        begin
          repeat (d) @(posedge ref_clk);
          safe_release();
        end
      join
      rchk(cfr_pkg::RFR_OFS, 32'h2, "count");
    end
    xfer(1'b0, cfr_pkg::IST_OFS, 32'h0, r);
    check(r & 32'hD, 32'h1, "events");
  endtask
  task automatic t_after_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(cfr_pkg::CTRL_OFS, 32'h0, "mode");
    rchk(cfr_pkg::IST_OFS, 32'h0, "events");
    cfr_can_node_i.send();
    rchk(cfr_pkg::RFR_OFS, 32'h1, "count");
    for (int i = 0; i < 2; i++) begin
      safe_release();
      rchk(cfr_pkg::RFR_OFS, 32'h0, "count");
    end
    rchk(cfr_pkg::DATA_OFS, 32'h0, "data");
  endtask
  task automatic t_live();
    fork
      cfr_can_node_i.send();
      begin
        repeat (20) @(posedge ref_clk);
        rchk(cfr_pkg::MSR_OFS, 32'h20, "status");
        rchk(cfr_pkg::DGR_OFS, 32'h0, "pin");
      end
    join
    rchk(cfr_pkg::MSR_OFS, 32'h0, "status");
    rchk(cfr_pkg::DGR_OFS, 32'h8, "pin");
  endtask
  task automatic t_timing();
    rchk(cfr_pkg::BTR_OFS, 32'h1A, "timing");
    wr(cfr_pkg::BTR_OFS, 32'h21);
    rchk(cfr_pkg::BTR_OFS, 32'h21, "timing");
    wr(cfr_pkg::BTR_OFS, 32'h12);
    rchk(cfr_pkg::BTR_OFS, 32'h21, "timing");
    wr(cfr_pkg::BTR_OFS, 32'h1FFF);
    rchk(cfr_pkg::BTR_OFS, 32'h1FFF, "timing");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(cfr_pkg::RFR_OFS, 32'h0, "count");
    rchk(8'h40, 32'h0, "unmapped");
    $display("idle reads done");
    t_fill();
    $display("fill done");
    t_sweep(1'b0);
    $display("fixed sweep done");
    t_sweep(1'b1);
    $display("faulty sweep done");
    t_safe();
    $display("safe release done");
    t_after_reset();
    $display("reset recovery done");
    t_live();
    $display("live status done");
    t_timing();
    $display("timing done");
    final_report();
  end
endmodule

// File: verilog/cfr_pkg.sv
package cfr_pkg;

  localparam logic [7:0] RFR_OFS  = 8'h00;
  localparam logic [7:0] MSR_OFS  = 8'h04;
  localparam logic [7:0] DGR_OFS  = 8'h08;
  localparam logic [7:0] BTR_OFS  = 8'h0C;
  localparam logic [7:0] DATA_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  localparam logic [7:0] IST_OFS  = 8'h18;
  localparam logic [7:0] IMSK_OFS = 8'h1C;

  localparam int RFR_RELEASE_BIT   = 5;
  localparam int MSR_ACTIVE_BIT    = 5;
  localparam int DGR_RX_BIT        = 3;
  localparam int CTRL_DEFECT_BIT   = 0;
  localparam int BTR_SEG2_LSB      = 0;
  localparam int BTR_SEG1_LSB      = 3;
  localparam int BTR_PRESC_LSB     = 7;

  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [1:0] PEND_TWO   = 2'h2;
  localparam logic [3:0] MAX_RECESSIVE = 4'h5;
  localparam logic [3:0] LOAD_RUN   = 4'h7;
  localparam logic [3:0] END_RUN    = 4'h8;
  localparam logic [4:0] MIN_TSEG_SUM = 5'h05;

  localparam int IRQ_W    = 4;
  localparam int IRQ_MSG  = 0;
  localparam int IRQ_FULL = 1;
  localparam int IRQ_OVR  = 2;
  localparam int IRQ_CORR = 3;

  typedef struct packed {
    logic [5:0] baud_prescaler;
    logic [3:0] time_segment_one;
    logic [2:0] time_segment_two;
  } cfr_bt_t;

  localparam cfr_bt_t BT_RESET = '{baud_prescaler:   6'h00,
                                   time_segment_one: 4'h3,
                                   time_segment_two: 3'h2};

  typedef enum logic {CFR_IDLE, CFR_RECEIVE} cfr_rx_state_t;

endpackage

// File: verilog/cfr_rx_fifo.sv
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
module cfr_rx_fifo #(
  parameter int MSG_W = 32
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        can_rx,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq
);

  // pointers wrap at the fifo depth, not at the two-bit limit
  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    return (p == cfr_pkg::FIFO_DEPTH - 2'h1) ? 2'h0 : p + 2'h1;
  endfunction

  // pin synchroniser: first stage feeds only the second
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_s3_reg;
  logic rx_level_reg;
  logic rx_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_s1_reg    <= 1'b1;
      rx_s2_reg    <= 1'b1;
      rx_s3_reg    <= 1'b1;
      rx_level_reg <= 1'b1;
      rx_prev_reg  <= 1'b1;
    end else begin
      rx_s1_reg   <= can_rx;
      rx_s2_reg   <= rx_s1_reg;
      rx_s3_reg   <= rx_s2_reg;
      rx_prev_reg <= rx_level_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_level_reg <= rx_s3_reg;
      end
    end
  end

  // bus front end
  // hsize is not decoded: only whole aligned words are mapped
  cfr_pkg::cfr_bt_t          bt_reg;
  logic                      defect_mode_reg;
  logic [cfr_pkg::IRQ_W-1:0] irq_status_reg;
  logic [cfr_pkg::IRQ_W-1:0] irq_mask_reg;
  logic                      wr_pend_reg;
  logic [7:0]                wr_addr_reg;
  logic                      addr_phase;
  logic                      wr_now;
  logic                      release_req;

  assign addr_phase  = hsel && hready && htrans[1];
  assign wr_now      = wr_pend_reg;
  assign release_req = wr_now && (wr_addr_reg == cfr_pkg::RFR_OFS)
                       && hwdata[cfr_pkg::RFR_RELEASE_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // bit timing: one quantum per prescaler wrap
  logic [5:0] presc_cnt_reg;
  logic [4:0] tq_cnt_reg;
  logic [4:0] bit_last_q;
  logic [4:0] sample_q;
  logic       tq_tick;
  logic       sample_en;
  logic       hard_sync;
  cfr_pkg::cfr_rx_state_t state_reg;

  // sync quantum + seg1 + seg2, so 8..25 quanta per bit
  assign bit_last_q = {1'b0, bt_reg.time_segment_one}
                      + {2'b00, bt_reg.time_segment_two}
                      + 5'h02;
  assign sample_q   = {1'b0, bt_reg.time_segment_one} + 5'h01;
  assign tq_tick    = presc_cnt_reg == bt_reg.baud_prescaler;
  assign sample_en  = tq_tick && (tq_cnt_reg == sample_q);
  // hard sync only from idle and no resync inside a frame, so the
  // far node has to run at the programmed rate
  assign hard_sync  = (state_reg == cfr_pkg::CFR_IDLE) && rx_prev_reg
                      && !rx_level_reg;

  always_ff @(posedge ref_clk) begin
    if (rst || hard_sync) begin
      presc_cnt_reg <= 6'h00;
      tq_cnt_reg    <= 5'h00;
    end else if (tq_tick) begin
      presc_cnt_reg <= 6'h00;
      tq_cnt_reg    <= (tq_cnt_reg >= bit_last_q) ? 5'h00
                                                   : tq_cnt_reg + 5'h01;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 6'h01;
    end
  end

  // frame tracking: a run of recessive samples after the last
  // dominant one marks the acknowledge tail, since stuffing caps
  // recessive runs inside a frame
  logic [3:0]       run_reg;
  logic [MSG_W-1:0] shift_reg;
  logic             load_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= cfr_pkg::CFR_IDLE;
      run_reg   <= 4'h0;
      shift_reg <= '0;
      load_reg  <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      if (sample_en) begin
        unique case (state_reg)
          cfr_pkg::CFR_IDLE: begin
            if (!rx_level_reg) begin
              state_reg <= cfr_pkg::CFR_RECEIVE;
              run_reg   <= 4'h0;
              shift_reg <= '0;
            end
          end
          cfr_pkg::CFR_RECEIVE: begin
            shift_reg <= {shift_reg[MSG_W-2:0], rx_level_reg};
            if (!rx_level_reg) begin
              run_reg <= 4'h0;
            end else begin
              run_reg <= run_reg + 4'h1;
              // a run past five can only be the frame tail
              if (run_reg == cfr_pkg::LOAD_RUN - 4'h1) begin
                load_reg <= 1'b1;
              end
              if (run_reg == cfr_pkg::END_RUN - 4'h1) begin
                state_reg <= cfr_pkg::CFR_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // receive FIFO
  logic [MSG_W-1:0] mem [0:2];
  logic [1:0]       wr_ptr_reg;
  logic [1:0]       rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             do_release;
  logic             do_load;
  logic             overrun;
  logic             corrupt;
  logic             both_now;

  // a release with nothing pending is ignored
  assign do_release = release_req && (count_reg != 2'h0);
  // a release in the same cycle makes room for the new message
  assign do_load    = load_reg
                      && (count_reg != cfr_pkg::FIFO_DEPTH || do_release);
  // overrun drops the new message and leaves both pointers alone
  assign overrun    = load_reg && !do_load;
  assign both_now   = do_load && do_release;
  assign corrupt    = both_now && defect_mode_reg
                      && (count_reg == cfr_pkg::PEND_TWO);

  always_ff @(posedge ref_clk) begin
    if (do_load) begin
      mem[wr_ptr_reg] <= shift_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg  <= 2'h0;
    end else if (both_now) begin
      rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      // defect keeps a stale write pointer; only reset heals it
      if (!corrupt) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
    end else if (do_load) begin
      wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      count_reg  <= count_reg + 2'h1;
    end else if (do_release) begin
      rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      count_reg  <= count_reg - 2'h1;
    end
  end

  // control registers
  // defect mode comes up off, i.e. the corrected pointer update
  logic [cfr_pkg::IRQ_W-1:0] irq_events;
  logic [cfr_pkg::IRQ_W-1:0] irq_clear;
  cfr_pkg::cfr_bt_t          bt_wdata;

  assign bt_wdata = hwdata[cfr_pkg::BTR_PRESC_LSB+5:
                           cfr_pkg::BTR_SEG2_LSB];

  always_comb begin
    irq_events = '0;
    irq_events[cfr_pkg::IRQ_MSG]  = do_load;
    irq_events[cfr_pkg::IRQ_FULL] = do_load && !do_release
                                    && (count_reg == cfr_pkg::PEND_TWO);
    irq_events[cfr_pkg::IRQ_OVR]  = overrun;
    irq_events[cfr_pkg::IRQ_CORR] = corrupt;
    irq_clear = '0;
    if (wr_now && wr_addr_reg == cfr_pkg::IST_OFS) begin
      irq_clear = hwdata[cfr_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bt_reg          <= cfr_pkg::BT_RESET;
      defect_mode_reg <= 1'b0;
      irq_mask_reg    <= '0;
    end else if (wr_now) begin
      // settings under eight quanta are refused
      if (wr_addr_reg == cfr_pkg::BTR_OFS
          && {1'b0, bt_wdata.time_segment_one}
             + {2'b00, bt_wdata.time_segment_two}
             >= cfr_pkg::MIN_TSEG_SUM) begin
        bt_reg <= bt_wdata;
      end
      if (wr_addr_reg == cfr_pkg::CTRL_OFS) begin
        defect_mode_reg <= hwdata[cfr_pkg::CTRL_DEFECT_BIT];
      end
      if (wr_addr_reg == cfr_pkg::IMSK_OFS) begin
        irq_mask_reg <= hwdata[cfr_pkg::IRQ_W-1:0];
      end
    end
  end

  // set beats clear when both land together
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_status_reg <= '0;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      irq            <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read data is captured at the address phase, so a read right
  // after a write to the same register sees the old value
  // unmapped reads return zero with an OKAY response
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      cfr_pkg::RFR_OFS:  rd_word[1:0] = count_reg;
      cfr_pkg::MSR_OFS:  rd_word[cfr_pkg::MSR_ACTIVE_BIT] =
                           state_reg == cfr_pkg::CFR_RECEIVE;
      cfr_pkg::DGR_OFS:  rd_word[cfr_pkg::DGR_RX_BIT] =
                           rx_level_reg;
      cfr_pkg::BTR_OFS:  rd_word[cfr_pkg::BTR_PRESC_LSB+5:0] = bt_reg;
      cfr_pkg::DATA_OFS: begin
        // empty reads 0, so a stale word shows only after a defect-mode corruption
        if (count_reg != 2'h0) begin
          rd_word[MSG_W-1:0] = mem[rd_ptr_reg];
        end
      end
      cfr_pkg::CTRL_OFS: rd_word[cfr_pkg::CTRL_DEFECT_BIT] =
                           defect_mode_reg;
      cfr_pkg::IST_OFS:  rd_word[cfr_pkg::IRQ_W-1:0] = irq_status_reg;
      cfr_pkg::IMSK_OFS: rd_word[cfr_pkg::IRQ_W-1:0] = irq_mask_reg;
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

endmodule
